/* opaddr_map.svh */
// Purpose: Constants for operand address generation
// Assumes: Included by bare name
// Notes:   Address bases and limits, reset values and timing counts
`ifndef OPADDR_MAP_SVH
`define OPADDR_MAP_SVH
`define BIT_RAM_LIMIT   8'h80
`define BIT_RAM_BASE    8'h20
`define SPECIAL_BASE    8'h80
`define INDIRECT_BANK   3'h0
`define MAX_LATENCY     2
`define RESET_BYTE      8'h00
`define RESET_WORD      16'h0000
`endif

/* opaddr_pkg.sv */
// Purpose: Types for operand address generation
// Assumes: None
// Notes:   Mode and target encodings
package opaddr_pkg;
    typedef enum logic [2:0] {
        MODE_DIRECT,
        MODE_INDIRECT8,
        MODE_INDIRECT16,
        MODE_REGISTER,
        MODE_IMPLIED,
        MODE_IMMEDIATE,
        MODE_INDEXED,
        MODE_BIT
    } addr_mode_t;
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_IRAM,
        TGT_SPECIAL,
        TGT_XDATA,
        TGT_CODE,
        TGT_VALUE
    } target_t;
endpackage

/* opaddr_bus_if.sv */
// Purpose: Carries a decoded request between stages
// Assumes: Single clock
// Notes:   Internal to the block
`timescale 1ns/10ps
`default_nettype none
interface opaddr_bus_if;
    import opaddr_pkg::*;
    logic         valid;
    addr_mode_t   mode;
    target_t      target;
    logic [15:0]  addr;
    logic [7:0]   value;
    logic [2:0]   bit_sel;
    logic         illegal;
    modport src (output valid, mode, target, addr, value, bit_sel, illegal);
    modport dst (input valid, mode, target, addr, value, bit_sel, illegal);
endinterface
`default_nettype wire

/* opaddr_calc.sv */
// Purpose: Combinational address formation per mode
// Assumes: Operand registers stable in the request cycle
// Notes:   Feeds the registered output stage
`timescale 1ns/10ps
`default_nettype none
`include "opaddr_map.svh"
module opaddr_calc
    import opaddr_pkg::*;
(
    // Request
    input  wire logic       req_valid,
    input  wire addr_mode_t req_mode,
    input  wire logic [7:0] field,
    input  wire logic [2:0] reg_sel,
    input  wire logic       ptr_sel,
    input  wire logic       is_movx,
    input  wire logic       is_code_read,
    // Core state
    input  wire logic [1:0] bank,
    input  wire logic [7:0] wr_zero,
    input  wire logic [7:0] wr_one,
    input  wire logic [15:0] data_pointer,
    input  wire logic [7:0] acc,
    // Result
    opaddr_bus_if.src       res
);
    logic [7:0] ind8;
    logic [7:0] bit_byte;
    always_comb begin
        ind8          = ptr_sel ? wr_one : wr_zero;
        bit_byte      = 8'h00;
        res.valid     = req_valid;
        res.mode      = req_mode;
        res.target    = TGT_NONE;
        res.addr      = `RESET_WORD;
        res.value     = `RESET_BYTE;
        res.bit_sel   = 3'h0;
        res.illegal   = 1'b0;
        case (req_mode)
            MODE_DIRECT: begin
                res.addr   = {8'h00, field};
                res.target = field[7] ? TGT_SPECIAL : TGT_IRAM;
                res.illegal = is_movx;
            end
            MODE_INDIRECT8: begin
                res.addr   = {8'h00, ind8};
                res.target = is_movx ? TGT_XDATA : TGT_IRAM;
            end
            MODE_INDIRECT16: begin
                res.addr    = data_pointer;
                res.target  = is_movx ? TGT_XDATA : TGT_NONE;
                res.illegal = !is_movx;
            end
            MODE_REGISTER: begin
                res.addr   = {8'h00, 3'h0, bank, reg_sel};
                res.target = TGT_IRAM;
                res.illegal = is_movx;
            end
            MODE_IMPLIED: begin
                res.value  = acc;
                res.target = TGT_VALUE;
            end
            MODE_IMMEDIATE: begin
                res.value  = field;
                res.target = TGT_VALUE;
                res.illegal = is_movx;
            end
            MODE_INDEXED: begin
                res.addr    = data_pointer + {8'h00, acc};
                res.target  = TGT_CODE;
                res.illegal = !is_code_read;
            end
            MODE_BIT: begin
                if (field < `BIT_RAM_LIMIT) begin
                    bit_byte   = `BIT_RAM_BASE + {3'h0, field[7:3]};
                    res.target = TGT_IRAM;
                end else begin
                    bit_byte   = {field[7:3], 3'h0};
                    res.target = TGT_SPECIAL;
                end
                res.addr    = {8'h00, bit_byte};
                res.bit_sel = field[2:0];
                res.illegal = is_movx;
            end
            default: begin
                res.illegal = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

/* operand_address_generation.sv */
// Purpose: Operand addressing for a pipelined 8-bit core
// Assumes: Decoder presents one request per cycle
// Notes:   One cycle from request to registered result
//
// Notes on behaviour
// - Direct field reaches internal RAM, special registers
// - 8-bit indirect uses register zero or one
// - 16-bit indirect uses data pointer
// - Register mode picks one of eight banked
// - Implied register used, no operand specifier
// - Immediate takes value from instruction bytes
// - Indexed: pointer plus accumulator, code reads only
// - Bit mode selects one of 256 bits
// - Address result within one to two cycles
// - 128 bits in RAM, rest special registers
// - External transfers only indirect, accumulator only
`timescale 1ns/10ps
`default_nettype none
`include "opaddr_map.svh"
module operand_address_generation
    import opaddr_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET,
    // Decoder request
    input  wire logic        REQ_VALID,
    input  wire addr_mode_t  REQ_MODE,
    input  wire logic [7:0]  FIELD,
    input  wire logic [2:0]  REG_SEL,
    input  wire logic        PTR_SEL,
    input  wire logic        IS_MOVX,
    input  wire logic        IS_CODE_READ,
    // Core state
    input  wire logic [1:0]  BANK,
    input  wire logic [7:0]  WR_ZERO,
    input  wire logic [7:0]  WR_ONE,
    input  wire logic [15:0] DATA_POINTER,
    input  wire logic [7:0]  ACC,
    // Result
    output logic             OUT_VALID,
    output var target_t      OUT_TARGET,
    output logic [15:0]      OUT_ADDR,
    output logic [7:0]       OUT_VALUE,
    output logic [2:0]       OUT_BIT,
    output logic             OUT_ILLEGAL
);
    opaddr_bus_if calc_bus ();

    opaddr_calc u_calc (
        .req_valid    (REQ_VALID),
        .req_mode     (REQ_MODE),
        .field        (FIELD),
        .reg_sel      (REG_SEL),
        .ptr_sel      (PTR_SEL),
        .is_movx      (IS_MOVX),
        .is_code_read (IS_CODE_READ),
        .bank         (BANK),
        .wr_zero      (WR_ZERO),
        .wr_one       (WR_ONE),
        .data_pointer (DATA_POINTER),
        .acc          (ACC),
        .res          (calc_bus.src)
    );

    logic        valid_r,   valid_nxt;
    target_t     target_r,  target_nxt;
    logic [15:0] addr_r,    addr_nxt;
    logic [7:0]  value_r,   value_nxt;
    logic [2:0]  bit_r,     bit_nxt;
    logic        illegal_r, illegal_nxt;

    // Result stage, one cycle latency
    always_comb begin
        valid_nxt   = calc_bus.valid;
        target_nxt  = calc_bus.valid ? calc_bus.target : TGT_NONE;
        addr_nxt    = calc_bus.valid ? calc_bus.addr : `RESET_WORD;
        value_nxt   = calc_bus.valid ? calc_bus.value : `RESET_BYTE;
        bit_nxt     = calc_bus.valid ? calc_bus.bit_sel : 3'h0;
        illegal_nxt = calc_bus.valid & calc_bus.illegal;
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            valid_r   <= 1'b0;
            target_r  <= TGT_NONE;
            addr_r    <= `RESET_WORD;
            value_r   <= `RESET_BYTE;
            bit_r     <= 3'h0;
            illegal_r <= 1'b0;
        end else begin
            valid_r   <= valid_nxt;
            target_r  <= target_nxt;
            addr_r    <= addr_nxt;
            value_r   <= value_nxt;
            bit_r     <= bit_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    assign OUT_VALID   = valid_r;
    assign OUT_TARGET  = target_r;
    assign OUT_ADDR    = addr_r;
    assign OUT_VALUE   = value_r;
    assign OUT_BIT     = bit_r;
    assign OUT_ILLEGAL = illegal_r;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    sequence s_req(addr_mode_t m);
        REQ_VALID && REQ_MODE == m;
    endsequence

    a_direct_target: assert property (
        s_req(MODE_DIRECT) |=> OUT_ADDR == {8'h00, $past(FIELD)}
            && (OUT_TARGET == TGT_SPECIAL || OUT_TARGET == TGT_IRAM))
        else $error("direct address wrong");
    a_indirect_reg: assert property (
        s_req(MODE_INDIRECT8) |=> OUT_ADDR[7:0] ==
            ($past(PTR_SEL) ? $past(WR_ONE) : $past(WR_ZERO)))
        else $error("indirect register wrong");
    a_pointer_addr: assert property (
        s_req(MODE_INDIRECT16) |=> OUT_ADDR == $past(DATA_POINTER))
        else $error("pointer address wrong");
    a_bank_reg: assert property (
        s_req(MODE_REGISTER) |=> OUT_ADDR == {11'h000, $past(BANK), $past(REG_SEL)})
        else $error("banked register wrong");
    a_implied_acc: assert property (
        s_req(MODE_IMPLIED) |=> OUT_VALUE == $past(ACC) && OUT_TARGET == TGT_VALUE)
        else $error("implied operand wrong");
    a_immediate_val: assert property (
        s_req(MODE_IMMEDIATE) |=> OUT_VALUE == $past(FIELD))
        else $error("immediate value wrong");
    a_indexed_code: assert property (
        s_req(MODE_INDEXED) |=> OUT_TARGET == TGT_CODE
            && OUT_ADDR == $past(DATA_POINTER) + {8'h00, $past(ACC)}
            && OUT_ILLEGAL == !$past(IS_CODE_READ))
        else $error("indexed read wrong");
    a_bit_space: assert property (
        s_req(MODE_BIT) |=> OUT_BIT == $past(FIELD[2:0])
            && (OUT_TARGET == TGT_SPECIAL) == $past(FIELD[7]))
        else $error("bit address wrong");
    a_latency_bound: assert property (
        REQ_VALID |-> ##[1:2] OUT_VALID)
        else $error("result late");
    a_special_bits: assert property (
        s_req(MODE_BIT) ##0 FIELD[7] |=> OUT_TARGET == TGT_SPECIAL
            && OUT_ADDR == {8'h00, $past(FIELD[7:3]), 3'h0})
        else $error("special bit byte wrong");
    a_xdata_only: assert property (
        OUT_VALID && OUT_TARGET == TGT_XDATA |-> $past(IS_MOVX))
        else $error("xdata without transfer");
    a_ram_bits: assert property (
        s_req(MODE_BIT) ##0 !FIELD[7] |=> OUT_TARGET == TGT_IRAM
            && OUT_ADDR == {8'h00, `BIT_RAM_BASE + {4'h0, $past(FIELD[6:3])}})
        else $error("ram bit byte wrong");
    a_direct_space: assert property (
        s_req(MODE_DIRECT) |=> (OUT_TARGET == TGT_SPECIAL) == $past(FIELD[7])
            && OUT_ILLEGAL == $past(IS_MOVX))
        else $error("direct space wrong");
    a_indirect_space: assert property (
        s_req(MODE_INDIRECT8) |=> OUT_TARGET == ($past(IS_MOVX) ? TGT_XDATA : TGT_IRAM)
            && !OUT_ILLEGAL)
        else $error("indirect space wrong");
    a_bank_target: assert property (
        s_req(MODE_REGISTER) |=> OUT_TARGET == TGT_IRAM
            && OUT_ILLEGAL == $past(IS_MOVX))
        else $error("banked register target wrong");
    a_immediate_tgt: assert property (
        s_req(MODE_IMMEDIATE) |=> OUT_TARGET == TGT_VALUE
            && OUT_ILLEGAL == $past(IS_MOVX))
        else $error("immediate target wrong");
    a_pointer_movx: assert property (
        s_req(MODE_INDIRECT16) |=> OUT_ILLEGAL == !$past(IS_MOVX)
            && (OUT_TARGET == TGT_XDATA) == $past(IS_MOVX))
        else $error("pointer transfer wrong");
    a_valid_follows: assert property (
        REQ_VALID |=> OUT_VALID)
        else $error("result missing");
    a_idle_quiet: assert property (
        !REQ_VALID |=> !OUT_VALID && OUT_TARGET == TGT_NONE
            && OUT_ADDR == 16'h0000 && OUT_VALUE == 8'h00
            && OUT_BIT == 3'h0 && !OUT_ILLEGAL)
        else $error("idle output not quiet");
endmodule
`default_nettype wire

/* opaddr_core_model.sv */
// Purpose: Core state model feeding the operand block
// Assumes: Single clock
// Notes:   State churns after each rising edge while asked
`timescale 1ns/10ps
`default_nettype none
module opaddr_core_model (
    // Control
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   churn,
    // Core state
    output logic [1:0]  bank,
    output logic [7:0]  wr_zero,
    output logic [7:0]  wr_one,
    output logic [15:0] data_pointer,
    output logic [7:0]  acc
);
    // Changes land after the edge that samples them
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {bank, wr_zero, wr_one, data_pointer, acc} <= '0;
        end else if (churn) begin
            {bank, wr_zero, wr_one, data_pointer, acc} <= 42'({$urandom, $urandom});
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for operand addressing
// Assumes: One cycle from request to result
// Notes:   Driver queues expectations, monitor pops them
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import opaddr_pkg::*;
    typedef struct packed {
        logic        ill_only;
        logic [2:0]  mask;
        target_t     tgt;
        logic [15:0] addr;
        logic [7:0]  val;
        logic [2:0]  bt;
        logic        ill;
    } exp_t;
    logic        MCLK = 1'b0;
    logic        RESET = 1'b1;
    logic        req_valid, ptr_sel, is_movx, is_code_read, churn, OUT_VALID, OUT_ILLEGAL;
    addr_mode_t  req_mode;
    target_t     OUT_TARGET;
    logic [7:0]  field, wr_zero, wr_one, acc, OUT_VALUE;
    logic [2:0]  reg_sel, OUT_BIT;
    logic [1:0]  bank;
    logic [15:0] data_pointer, OUT_ADDR;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    exp_t        q[$];
    logic [7:0]  edge_vals [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};

    always #5 MCLK = ~MCLK;

    opaddr_core_model i_core (.clk(MCLK), .rst(RESET), .churn(churn), .bank(bank),
        .wr_zero(wr_zero), .wr_one(wr_one), .data_pointer(data_pointer), .acc(acc));
    operand_address_generation i_dut (.MCLK(MCLK), .RESET(RESET), .REQ_VALID(req_valid),
        .REQ_MODE(req_mode), .FIELD(field), .REG_SEL(reg_sel), .PTR_SEL(ptr_sel),
        .IS_MOVX(is_movx), .IS_CODE_READ(is_code_read), .BANK(bank), .WR_ZERO(wr_zero),
        .WR_ONE(wr_one), .DATA_POINTER(data_pointer), .ACC(acc), .OUT_VALID(OUT_VALID),
        .OUT_TARGET(OUT_TARGET), .OUT_ADDR(OUT_ADDR), .OUT_VALUE(OUT_VALUE),
        .OUT_BIT(OUT_BIT), .OUT_ILLEGAL(OUT_ILLEGAL));

    task automatic check(logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic send(addr_mode_t m, logic [7:0] f, logic x, logic c);
        exp_t e;
        @(negedge MCLK);
        req_valid = 1'b1;
        req_mode = m;
        field = f;
        reg_sel = 3'($urandom);
        ptr_sel = 1'($urandom);
        is_movx = x;
        is_code_read = c;
        e = '0;
        e.mask = 3'b100;
        e.ill = (x && m inside {MODE_DIRECT, MODE_REGISTER, MODE_IMMEDIATE, MODE_BIT})
            || (m == MODE_INDIRECT16 && !x) || (m == MODE_INDEXED && !c);
        e.ill_only = e.ill;
        case (m)
            MODE_DIRECT:     e.addr = {8'h00, f};
            MODE_INDIRECT8:  e.addr = {8'h00, ptr_sel ? wr_one : wr_zero};
            MODE_INDIRECT16: e.addr = data_pointer;
            MODE_REGISTER:   e.addr = {11'h000, bank, reg_sel};
            MODE_INDEXED:    e.addr = data_pointer + {8'h00, acc};
            MODE_BIT:        e.addr = f[7] ? {8'h00, f[7:3], 3'h0} : 16'h0020 + f[6:3];
            default:         e.mask = 3'b010;
        endcase
        if (m == MODE_BIT) begin
            e.mask = 3'b101;
        end
        e.val = (m == MODE_IMPLIED) ? acc : f;
        e.bt = f[2:0];
        e.tgt = (m inside {MODE_IMPLIED, MODE_IMMEDIATE}) ? TGT_VALUE
            : (m == MODE_INDEXED) ? TGT_CODE
            : (m == MODE_INDIRECT16 || (m == MODE_INDIRECT8 && x)) ? TGT_XDATA
            : (f[7] && m inside {MODE_DIRECT, MODE_BIT}) ? TGT_SPECIAL : TGT_IRAM;
        q.push_back(e);
    endtask

    task automatic legal(addr_mode_t m, logic [7:0] f);
        send(m, f, m == MODE_INDIRECT16 || (m == MODE_INDIRECT8 && f[0]), m == MODE_INDEXED);
    endtask

    task automatic idle();
        @(negedge MCLK);
        req_valid = 1'b0;
    endtask

    // Monitor: result exactly one cycle after each taken request
    always @(posedge MCLK) begin
        exp_t e;
        logic was;
        was = req_valid && !RESET;
        #1;
        if (!RESET) begin
            check(OUT_VALID, was);
            if (OUT_VALID === 1'b1 && q.size() > 0) begin
                e = q.pop_front();
                check(OUT_ILLEGAL, e.ill);
                if (!e.ill_only) begin
                    check(OUT_TARGET, e.tgt);
                    if (e.mask[2]) check(OUT_ADDR, e.addr);
                    if (e.mask[1]) check(OUT_VALUE, e.val);
                    if (e.mask[0]) check(OUT_BIT, e.bt);
                end
            end else begin
                check(OUT_TARGET, TGT_NONE);
                check(OUT_ADDR | OUT_VALUE | OUT_BIT | OUT_ILLEGAL, 16'h0000);
            end
        end
    end

    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        {req_valid, ptr_sel, is_movx, is_code_read, churn, field, reg_sel} = '0;
        req_mode = MODE_DIRECT;
        void'($urandom(32'h04a9_23f6));
        repeat (2) @(negedge MCLK);
        check(OUT_VALID, 1'b0);
        check(OUT_TARGET, TGT_NONE);
        RESET = 1'b0;
        churn = 1'b1;
        // Every mode at field boundaries, back to back
        for (int m = 0; m < 8; m++) begin
            foreach (edge_vals[i]) legal(addr_mode_t'(m), edge_vals[i]);
        end
        $display("modes test done");
        // Disallowed combinations flagged
        for (int m = 0; m < 8; m++) begin
            if (!(m inside {MODE_IMPLIED, MODE_INDIRECT8})) begin
                send(addr_mode_t'(m), 8'($urandom), m != MODE_INDIRECT16, 1'b0);
            end
        end
        idle();
        $display("illegal test done");
        repeat (300) begin
            if ($urandom_range(3, 0) == 0) idle();
            else legal(addr_mode_t'($urandom_range(7, 0)), 8'($urandom));
        end
        $display("random test done");
        // Reset in mid-run clears the result already delivered half a cycle earlier
        legal(MODE_INDEXED, 8'h00);
        @(negedge MCLK);
        RESET = 1'b1;
        req_valid = 1'b0;
        q.delete();
        #1;
        check(OUT_VALID, 1'b0);
        @(negedge MCLK);
        RESET = 1'b0;
        repeat (3) idle();
        check(q.size(), 16'h0000);
        $display("reset test done");
        end_sim();
    end
endmodule
`default_nettype wire
